// file: rtl/brtc_rtc_target.sv
`timescale 1ns/100ps
module brtc_rtc_target #(
    parameter int OSC_STOP_CYCLES = brtc_pkg::OSC_STOP_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic xtalIn,
    output logic intOut,
    output logic intOe,
    output logic freqOut,
    output logic freqOe
);
    brtc_pkg::brtc_state_t q;
    brtc_pkg::brtc_state_t n;
    logic sclRise, sclFall, busStart, busStop, xRise, xEdge;
    logic stopBit, secTick, minTick, oscDead, advance, tmrTick;
    logic [7:0] readByte;
    logic [8:0] t;

    function automatic logic [8:0] bcdNext(input logic [7:0] v,
        input logic [7:0] last, input logic [7:0] first);
        logic [8:0] r;
        if (v >= last) begin
            r = {1'b1, first};
        end else if (v[3:0] >= 4'h9) begin
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {1'b0, v + 8'h01};
        end
        return r;
    endfunction

    function automatic logic [7:0] monthLast(input logic [7:0] m,
        input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m)
            8'h02: monthLast = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: monthLast = 8'h30;
            default: monthLast = 8'h31;
        endcase
    endfunction

    function automatic brtc_pkg::brtc_state_t rstState();
        brtc_pkg::brtc_state_t s;
        s = '0;
        s.st = brtc_pkg::ST_IDLE;
        s.sclPrev = 1'b1;
        s.sdaPrev = 1'b1;
        s.regs = brtc_pkg::REG_RESET;
        return s;
    endfunction
    localparam brtc_pkg::brtc_state_t RST_STATE = rstState();

    always_comb begin
        n = q;
        t = '0;
        minTick = 1'b0;
        tmrTick = 1'b0;
        // inputs are synchronous, edges from last sample
        sclRise = sclIn & ~q.sclPrev;
        sclFall = ~sclIn & q.sclPrev;
        // start and stop conditions for bit rates up to 400 kbit/s
        busStart = q.sclPrev & sclIn & q.sdaPrev & ~sdaIn;
        busStop = q.sclPrev & sclIn & ~q.sdaPrev & sdaIn;
        xRise = xtalIn & ~q.xtalPrev;
        xEdge = xtalIn ^ q.xtalPrev;
        n.sclPrev = sclIn;
        n.sdaPrev = sdaIn;
        n.xtalPrev = xtalIn;
        // unimplemented bits read zero
        readByte = q.regs[q.ptr] & brtc_pkg::REG_MASK[q.ptr];
        // divider held clear while stopped
        stopBit = q.regs[brtc_pkg::REG_CTRL1][brtc_pkg::BIT_STOP];
        secTick = xRise & (&q.div) & ~stopBit;
        if (stopBit) begin
            n.div = '0;
        end else if (xRise) begin
            n.div = q.div + 1'b1;
        end
        // oscillator watchdog
        n.oscIdle = xEdge ? '0 : q.oscIdle + 1'b1;
        oscDead = q.oscIdle == brtc_pkg::OSC_IDLE_W'(OSC_STOP_CYCLES - 1);
        // serial target
        if (busStart) begin
            n.st = brtc_pkg::ST_ADDR;
            n.bitCnt = '0;
            n.sdaOe = 1'b0;
            n.reading = 1'b0;
        end else if (busStop) begin
            n.st = brtc_pkg::ST_IDLE;
            n.sdaOe = 1'b0;
            n.reading = 1'b0;
        end else begin
            case (q.st)
                brtc_pkg::ST_ADDR, brtc_pkg::ST_WDATA: begin
                    if (sclRise) begin
                        n.shift = {q.shift[6:0], sdaIn};
                        n.bitCnt = q.bitCnt + 4'h1;
                    end else if (sclFall && q.bitCnt == 4'h8) begin
                        n.bitCnt = '0;
                        if (q.st == brtc_pkg::ST_ADDR) begin
                            if (q.shift[7:1] == brtc_pkg::ADDR_WR[7:1]) begin
                                n.st = brtc_pkg::ST_ACKOUT;
                                n.sdaOe = 1'b1;
                                n.rw = q.shift[0];
                                n.reading = q.shift[0];
                                n.ptrLoaded = 1'b0;
                            end else begin
                                n.st = brtc_pkg::ST_IDLE;
                            end
                        end else begin
                            n.st = brtc_pkg::ST_ACKOUT;
                            n.sdaOe = 1'b1;
                            if (!q.ptrLoaded) begin
                                n.ptr = q.shift[3:0];
                                n.ptrLoaded = 1'b1;
                            end else begin
                                n.regs[q.ptr] = q.shift & brtc_pkg::REG_MASK[q.ptr];
                                if (q.ptr == brtc_pkg::REG_CTRL2) begin
                                    // flags clear on zero, keep on one
                                    n.regs[q.ptr][brtc_pkg::BIT_AF] = q.shift[brtc_pkg::BIT_AF]
                                        & q.regs[q.ptr][brtc_pkg::BIT_AF];
                                    n.regs[q.ptr][brtc_pkg::BIT_TF] = q.shift[brtc_pkg::BIT_TF]
                                        & q.regs[q.ptr][brtc_pkg::BIT_TF];
                                end
                                if (q.ptr == brtc_pkg::REG_TVAL) begin
                                    n.timerCnt = q.shift;
                                end
                                n.ptr = q.ptr + 4'h1;
                            end
                        end
                    end
                end
                brtc_pkg::ST_ACKOUT: begin
                    if (sclFall) begin
                        n.bitCnt = '0;
                        if (q.rw) begin
                            n.st = brtc_pkg::ST_RDATA;
                            n.shift = readByte;
                            n.sdaOe = ~readByte[7];
                        end else begin
                            n.st = brtc_pkg::ST_WDATA;
                            n.sdaOe = 1'b0;
                        end
                    end
                end
                brtc_pkg::ST_RDATA: begin
                    if (sclRise) begin
                        n.bitCnt = q.bitCnt + 4'h1;
                    end else if (sclFall) begin
                        if (q.bitCnt == 4'h8) begin
                            n.st = brtc_pkg::ST_ACKIN;
                            n.sdaOe = 1'b0;
                            n.bitCnt = '0;
                            n.ptr = q.ptr + 4'h1;
                        end else begin
                            n.shift = {q.shift[6:0], 1'b0};
                            n.sdaOe = ~q.shift[6];
                        end
                    end
                end
                brtc_pkg::ST_ACKIN: begin
                    if (sclRise) begin
                        if (sdaIn) begin
                            n.st = brtc_pkg::ST_IDLE;
                        end else begin
                            n.bitCnt = 4'h9;
                        end
                    end else if (sclFall && q.bitCnt == 4'h9) begin
                        n.st = brtc_pkg::ST_RDATA;
                        n.bitCnt = '0;
                        n.shift = readByte;
                        n.sdaOe = ~readByte[7];
                    end
                end
                brtc_pkg::ST_IDLE: n.sdaOe = 1'b0;
                default: begin
                    n.st = brtc_pkg::ST_IDLE;
                    n.sdaOe = 1'b0;
                end
            endcase
        end
        // time advance, deferred while a read holds the counters
        advance = (secTick | q.pendSec) & ~q.reading;
        if (q.reading && secTick) begin
            n.pendSec = 1'b1;
        end else if (advance) begin
            n.pendSec = 1'b0;
        end
        if (advance) begin
            t = bcdNext({1'b0, q.regs[2][6:0]}, 8'h59, 8'h00);
            n.regs[2][6:0] = t[6:0];
            if (t[8]) begin
                minTick = 1'b1;
                t = bcdNext(q.regs[3], 8'h59, 8'h00);
                n.regs[3] = t[7:0];
            end
            if (t[8]) begin
                t = bcdNext(q.regs[4], 8'h23, 8'h00);
                n.regs[4] = t[7:0];
            end
            if (t[8]) begin
                n.regs[6] = 8'(bcdNext(q.regs[6], 8'h06, 8'h00));
                t = bcdNext(q.regs[5], monthLast(q.regs[7] & 8'h1F, q.regs[8]), 8'h01);
                n.regs[5] = t[7:0];
            end
            if (t[8]) begin
                t = bcdNext({3'h0, q.regs[7][4:0]}, 8'h12, 8'h01);
                n.regs[7][4:0] = t[4:0];
            end
            if (t[8]) begin
                t = bcdNext(q.regs[8], 8'h99, 8'h00);
                n.regs[8] = t[7:0];
                n.regs[7][brtc_pkg::BIT_TOP] = q.regs[7][brtc_pkg::BIT_TOP] ^ t[8];
            end
        end
        // alarm on each new minute, disabled fields match any value, but no alarm when all four are disabled
        if (minTick && ~&{q.regs[9][7], q.regs[10][7], q.regs[11][7], q.regs[12][7]}
            && (q.regs[9][7] || q.regs[9][6:0] == n.regs[3][6:0])
            && (q.regs[10][7] || q.regs[10][5:0] == n.regs[4][5:0])
            && (q.regs[11][7] || q.regs[11][5:0] == n.regs[5][5:0])
            && (q.regs[12][7] || q.regs[12][2:0] == n.regs[6][2:0])) begin
            n.regs[1][brtc_pkg::BIT_AF] = 1'b1;
        end
        // countdown timer sources
        case (q.regs[brtc_pkg::REG_TCTL][1:0])
            2'h0: tmrTick = xRise & (&q.div[2:0]) & ~stopBit;
            2'h1: tmrTick = xRise & (&q.div[8:0]) & ~stopBit;
            2'h2: tmrTick = secTick;
            default: tmrTick = minTick;
        endcase
        if (tmrTick && q.regs[brtc_pkg::REG_TCTL][brtc_pkg::BIT_TOP]) begin
            if (q.timerCnt <= 8'h01) begin
                n.timerCnt = q.regs[brtc_pkg::REG_TVAL];
                n.regs[1][brtc_pkg::BIT_TF] = 1'b1;
            end else begin
                n.timerCnt = q.timerCnt - 8'h01;
            end
        end
        // open-drain pins pull low when enabled
        n.intOe = (q.regs[1][brtc_pkg::BIT_AF] & q.regs[1][brtc_pkg::BIT_AIE])
                | (q.regs[1][brtc_pkg::BIT_TF] & q.regs[1][brtc_pkg::BIT_TIE]);
        case (q.regs[brtc_pkg::REG_CLKSEL][1:0])
            2'h0: n.freqOe = ~q.xtalPrev;
            2'h1: n.freqOe = ~q.div[4];
            2'h2: n.freqOe = ~q.div[9];
            default: n.freqOe = ~q.div[14];
        endcase
        if (!q.regs[brtc_pkg::REG_CLKSEL][brtc_pkg::BIT_TOP]) begin
            n.freqOe = 1'b0;
        end
        n.zero = 1'b0;
        if (oscDead) begin
            n = RST_STATE;
            n.sclPrev = sclIn;
            n.sdaPrev = sdaIn;
            n.xtalPrev = xtalIn;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            q <= RST_STATE;
        end else begin
            q <= n;
        end
    end

    assign sdaOut = q.zero;
    assign sdaOe = q.sdaOe;
    assign intOut = q.zero;
    assign intOe = q.intOe;
    assign freqOut = q.zero;
    assign freqOe = q.freqOe;

    property p_ptr_inc;
        @(posedge clock) disable iff (!resetn)
        (q.st == brtc_pkg::ST_RDATA && sclFall && q.bitCnt == 4'h8 && !busStart
         && !busStop && !oscDead) |=> q.ptr == $past(q.ptr) + 4'h1;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not step");
    property p_addr_ack;
        @(posedge clock) disable iff (!resetn)
        (q.st == brtc_pkg::ST_ADDR && sclFall && q.bitCnt == 4'h8 && !oscDead
         && (q.shift == brtc_pkg::ADDR_WR || q.shift == brtc_pkg::ADDR_RD))
        |=> q.sdaOe && q.st == brtc_pkg::ST_ACKOUT && q.reading == q.rw;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");
    property p_addr_nack;
        @(posedge clock) disable iff (!resetn)
        (q.st == brtc_pkg::ST_ADDR && sclFall && q.bitCnt == 4'h8
         && q.shift[7:1] != brtc_pkg::ADDR_WR[7:1]) |=> !q.sdaOe [*2];
    endproperty
    a_addr_nack: assert property (p_addr_nack) else $error("foreign address acked");
    property p_freeze;
        @(posedge clock) disable iff (!resetn)
        (q.reading && !oscDead) |=> $stable(q.regs[8:2]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("time moved during read");
    property p_pend;
        @(posedge clock) disable iff (!resetn)
        (q.reading && secTick && !oscDead) |=> q.pendSec;
    endproperty
    a_pend: assert property (p_pend) else $error("tick lost during read");
    property p_stop;
        @(posedge clock) disable iff (!resetn)
        (stopBit && !oscDead) |=> q.div == '0 ##1 !secTick;
    endproperty
    a_stop: assert property (p_stop) else $error("divider ran while stopped");
    property p_int;
        @(posedge clock) disable iff (!resetn)
        !oscDead |=> intOe
            == $past((q.regs[1][3] & q.regs[1][1]) | (q.regs[1][2] & q.regs[1][0]));
    endproperty
    a_int: assert property (p_int) else $error("interrupt pin wrong");
    property p_read_mask;
        @(posedge clock) disable iff (!resetn)
        (q.st == brtc_pkg::ST_ACKOUT && sclFall && q.rw && !busStart && !busStop
         && !oscDead) |=> q.shift == $past(readByte) && sdaOe == !q.shift[7];
    endproperty
    a_read_mask: assert property (p_read_mask) else $error("bad read byte");
    property p_osc_rst;
        @(posedge clock) disable iff (!resetn)
        oscDead |=> q.ptr == 4'h0 && q.st == brtc_pkg::ST_IDLE && !sdaOe;
    endproperty
    a_osc_rst: assert property (p_osc_rst) else $error("no reset on dead osc");
    property p_bcd;
        @(posedge clock) disable iff (!resetn)
        advance |=> q.regs[2][3:0] <= 4'h9 && q.regs[2][6:4] <= 3'h5;
    endproperty
    a_bcd: assert property (p_bcd) else $error("seconds not BCD");
    c_read: cover property (@(posedge clock) disable iff (!resetn)
        q.st == brtc_pkg::ST_ACKIN ##[1:1000] q.st == brtc_pkg::ST_RDATA);
    c_write: cover property (@(posedge clock) disable iff (!resetn)
        q.ptrLoaded && q.st == brtc_pkg::ST_ACKOUT && !q.rw);
    c_pend: cover property (@(posedge clock) disable iff (!resetn)
        q.pendSec && !q.reading);
endmodule

// file: rtl/brtc_pkg.sv
package brtc_pkg;
    // register locations
    localparam logic [3:0] REG_CTRL1 = 4'h0;
    localparam logic [3:0] REG_CTRL2 = 4'h1;
    localparam logic [3:0] REG_SEC = 4'h2;
    localparam logic [3:0] REG_MIN = 4'h3;
    localparam logic [3:0] REG_HOUR = 4'h4;
    localparam logic [3:0] REG_DAY = 4'h5;
    localparam logic [3:0] REG_WDAY = 4'h6;
    localparam logic [3:0] REG_MON = 4'h7;
    localparam logic [3:0] REG_YEAR = 4'h8;
    localparam logic [3:0] REG_AMIN = 4'h9;
    localparam logic [3:0] REG_AHOUR = 4'hA;
    localparam logic [3:0] REG_ADAY = 4'hB;
    localparam logic [3:0] REG_AWDAY = 4'hC;
    localparam logic [3:0] REG_CLKSEL = 4'hD;
    localparam logic [3:0] REG_TCTL = 4'hE;
    localparam logic [3:0] REG_TVAL = 4'hF;
    // bus addresses
    localparam logic [7:0] ADDR_WR = 8'hA2;
    localparam logic [7:0] ADDR_RD = 8'hA3;
    localparam int BUS_MAX_KBPS = 400;
    // field positions
    localparam int BIT_STOP = 5;
    localparam int BIT_AF = 3;
    localparam int BIT_TF = 2;
    localparam int BIT_AIE = 1;
    localparam int BIT_TIE = 0;
    localparam int BIT_TOP = 7;
    // implemented bits, location 15 leftmost
    localparam logic [15:0][7:0] REG_MASK = {
        8'hFF, 8'h83, 8'h83, 8'h87, 8'hBF, 8'hBF, 8'hFF, 8'hFF,
        8'h9F, 8'h07, 8'h3F, 8'h3F, 8'h7F, 8'hFF, 8'h1F, 8'hA8};
    localparam logic [15:0][7:0] REG_RESET = {
        8'h00, 8'h03, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00,
        8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h80, 8'h00, 8'h08};
    // divider: 32768 oscillator rising edges per second
    localparam int DIV_W = 15;
    localparam int OSC_IDLE_W = 16;
    localparam int OSC_STOP_CYCLES = 16384;
    localparam logic [2:0] BITS_PER_BYTE = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_WDATA, ST_ACKOUT, ST_RDATA, ST_ACKIN
    } brtc_i2c_st_t;

    typedef struct packed {
        brtc_i2c_st_t st;
        logic [7:0] shift;
        logic [3:0] bitCnt;
        logic rw;
        logic ptrLoaded;
        logic [3:0] ptr;
        logic sclPrev;
        logic sdaPrev;
        logic xtalPrev;
        logic sdaOe;
        logic reading;
        logic pendSec;
        logic [DIV_W-1:0] div;
        logic [OSC_IDLE_W-1:0] oscIdle;
        logic [7:0] timerCnt;
        logic intOe;
        logic freqOe;
        logic zero;
        logic [15:0][7:0] regs;
    } brtc_state_t;
endpackage

// file: tb/brtc_i2c_host.sv
`timescale 1ns/100ps
module brtc_i2c_host #(
    parameter int QUARTER = 79
) (
    input wire logic clock,
    input wire logic sdaLine,
    output logic sclOut,
    output logic sdaOe,
    output logic [7:0] resVal,
    output logic resValid
);
    // released lines, both pulled up
    initial begin
        sclOut = 1'b1;
        sdaOe = 1'b0;
        resVal = 8'h00;
        resValid = 1'b0;
    end

    // four quarters per bit keep the rate under 400 kbit/s
    task automatic waitq();
        repeat (QUARTER) @(posedge clock);
    endtask

    task automatic post(input logic [7:0] v);
        resVal <= v;
        resValid <= 1'b1;
        @(posedge clock);
        resValid <= 1'b0;
    endtask

    // also serves as repeated start
    task automatic start();
        sdaOe <= 1'b0;
        waitq();
        sclOut <= 1'b1;
        waitq();
        sdaOe <= 1'b1;
        waitq();
        sclOut <= 1'b0;
        waitq();
    endtask

    task automatic stop();
        sdaOe <= 1'b1;
        waitq();
        sclOut <= 1'b1;
        waitq();
        sdaOe <= 1'b0;
        waitq();
    endtask

    // data changes only while the clock line is low
    task automatic bitx(input logic b, output logic r);
        sdaOe <= ~b;
        waitq();
        sclOut <= 1'b1;
        waitq();
        r = sdaLine;
        waitq();
        sclOut <= 1'b0;
        waitq();
    endtask

    task automatic wrByte(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(b[i], r);
        end
        bitx(1'b1, r);
        post({7'h00, r});
    endtask

    task automatic rdByte(input logic last);
        logic [7:0] d;
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, d[i]);
        end
        bitx(last, r);
        post(d);
    endtask
endmodule

// file: tb/brtc_rtc_target_bench.sv
`timescale 1ns/100ps
module brtc_rtc_target_bench;
    logic clock;
    logic resetn;
    logic xtal;
    logic xtalRun;
    logic sclLine;
    logic hostSdaOe;
    logic resValid;
    logic [7:0] resVal;
    logic [7:0] rnd;
    logic [7:0] toggles;
    logic prevF;
    logic sdaOut;
    logic sdaOe;
    logic intOut;
    logic intOe;
    logic freqOut;
    logic freqOe;
    wire logic sdaLine;
    logic [7:0] expQ[$];
    int miscompares;
    int cmp_count;
    int cycles;

    // open drain with pull-up
    assign sdaLine = ~(hostSdaOe | sdaOe);

    brtc_rtc_target #(.OSC_STOP_CYCLES(64)) dut (
        .clock(clock), .resetn(resetn), .sclIn(sclLine), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .xtalIn(xtal), .intOut(intOut),
        .intOe(intOe), .freqOut(freqOut), .freqOe(freqOe));

    brtc_i2c_host #(.QUARTER(79)) host (
        .clock(clock), .sdaLine(sdaLine), .sclOut(sclLine), .sdaOe(hostSdaOe),
        .resVal(resVal), .resValid(resValid));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // fast oscillator: one second is 65536 clocks
    always @(posedge clock) begin
        if (xtalRun) begin
            xtal <= ~xtal;
        end
    end

    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        cmp_count++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 99000) begin
            miscompares++;
            final_report();
        end
    end

    // oldest note against each acknowledge or read byte
    always @(posedge clock) begin
        if (resValid === 1'b1) begin
            check(resVal, (expQ.size() > 0) ? expQ.pop_front() : 8'hXX);
        end
    end

    task automatic wr(input logic [7:0] b, input logic nack = 1'b0);
        expQ.push_back({7'h00, nack});
        host.wrByte(b);
    endtask

    task automatic rd(input logic [7:0] want, input logic last);
        expQ.push_back(want);
        host.rdByte(last);
    endtask

    initial begin
        resetn = 1'b0;
        xtal = 1'b0;
        xtalRun = 1'b1;
        cycles = 0;
        miscompares = 0;
        cmp_count = 0;
        void'($urandom(32'h5B8F));
        rnd = 8'($urandom());
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
        // set 22:59:59, weekday with unused bits set
        host.start();
        wr(brtc_pkg::ADDR_WR);
        wr(8'h02);
        wr(8'h59);
        wr(8'h59);
        wr(8'h22);
        wr(8'h01);
        wr(8'hFF);
        host.stop();
        // foreign address is not acknowledged
        host.start();
        wr(8'hA4, 1'b1);
        host.stop();
        // second data byte wraps to 00h, reserved bits written zero
        host.start();
        wr(brtc_pkg::ADDR_WR);
        wr(8'h0F);
        wr(rnd);
        wr(8'h00);
        host.start();
        wr(brtc_pkg::ADDR_WR);
        wr(8'h0F);
        host.start();
        wr(brtc_pkg::ADDR_RD);
        rd(rnd, 1'b0);
        rd(8'h00, 1'b0);
        rd(8'h00, 1'b1);
        host.stop();
        // default output follows the oscillator
        toggles = 8'h00;
        #1;
        prevF = freqOe;
        repeat (16) begin
            @(posedge clock);
            #1;
            if (freqOe !== prevF) toggles++;
            prevF = freqOe;
        end
        check(toggles, 8'h10);
        // past the first second tick, pointer left at 02h
        while (cycles < 67000) @(posedge clock);
        host.start();
        wr(brtc_pkg::ADDR_RD);
        rd(8'h00, 1'b0);
        rd(8'h00, 1'b0);
        rd(8'h23, 1'b0);
        rd(8'h01, 1'b0);
        rd(8'h07, 1'b1);
        host.stop();
        // stopped oscillator resets registers and pointer
        xtalRun <= 1'b0;
        repeat (200) @(posedge clock);
        xtalRun <= 1'b1;
        repeat (8) @(posedge clock);
        host.start();
        wr(brtc_pkg::ADDR_RD);
        rd(8'h08, 1'b0);
        rd(8'h00, 1'b0);
        rd(8'h80, 1'b1);
        host.stop();
        repeat (4) @(posedge clock);
        check({7'h00, intOe}, 8'h00);
        check({5'h00, sdaOut, intOut, freqOut}, 8'h00);
        check({7'h00, sdaOe}, 8'h00);
        check(8'(expQ.size()), 8'h00);
        final_report();
    end
endmodule
